// File: core/lvd_ctrl.sv
/*
  Supply drop detector control: mode and level registers on APB, comparator
  synchroniser, interrupt and internal reset request generation, lock of the
  configuration once reset mode is armed.
  Assumes srst_i comes only from reset sources other than this detector, so
  the registers ride through a reset that the detector itself requests. The
  analog comparator, reset controller and interrupt controller sit outside.
  The system clock keeps running in STOP mode for this block.
*/
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "lvd_map.svh"
`default_nettype none

module lvd_ctrl (
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  // APB slave
  input  wire lvd_pkg::lvd_apb_req_s apb_req_i,
  output var  lvd_pkg::lvd_apb_rsp_s apb_rsp_o,
  // Analog comparator
  input  wire logic                  cmp_below_i,
  output logic                       cmp_enable_o,
  output logic [2:0]                 level_code_o,
  // Requests to interrupt and reset controllers
  output logic                       supply_drop_irq_o,
  output logic                       supply_drop_reset_req_o,
  output logic                       supply_reset_source_flag_set_o
);

  // Address decode, used by both the read mux and the write logic
  function automatic lvd_pkg::lvd_sel_e decode(input logic [11:0] addr);
    lvd_pkg::lvd_sel_e sel;
    sel = lvd_pkg::LVD_SEL_NONE;
    unique case (addr)
      `LVD_ADDR_MODE:    sel = lvd_pkg::LVD_SEL_MODE;
      `LVD_ADDR_LEVEL:   sel = lvd_pkg::LVD_SEL_LEVEL;
      `LVD_ADDR_PROTECT: sel = lvd_pkg::LVD_SEL_PROTECT;
      default:           sel = lvd_pkg::LVD_SEL_NONE;
    endcase
    return sel;
  endfunction

  lvd_pkg::lvd_mode_s mode_q;
  logic [2:0]         level_q;
  logic               unlock_q;
  logic               sync1_q;
  logic               sync2_q;
  logic               flag_q;
  logic               fired_q;
  logic               reset_req_q;
  logic [31:0]        prdata_q;
  lvd_pkg::lvd_sel_e  sel;
  logic               wr_en;
  logic               rd_en;
  logic               armed;
  logic               cfg_locked;

  // Reset images; a bare literal cannot be bit-selected, so it is named first
  localparam logic [7:0] MODE_RST_VAL  = `LVD_MODE_RST_VAL;
  localparam logic [7:0] LEVEL_RST_VAL = `LVD_LEVEL_RST_VAL;

  // Transfer completes in its first access cycle; no wait states
  assign sel   = decode(apb_req_i.paddr);
  assign wr_en = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign rd_en = apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite;

  // Reset mode armed; config frozen until the first reset request fires
  assign armed      = mode_q.detect_enable && mode_q.reset_mode_select;
  assign cfg_locked = armed && !fired_q;

  // Protected write window: key write opens it, the next write closes it
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      unlock_q <= 1'b0;
    end else if (wr_en) begin
      unlock_q <= (sel == lvd_pkg::LVD_SEL_PROTECT) &&
                  (apb_req_i.pwdata[7:0] == `LVD_PROTECT_KEY);
    end
  end

  // Mode register; srst_i is never the detector's own reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mode_q <= lvd_pkg::lvd_mode_s'({MODE_RST_VAL[`LVD_MODE_EN_BIT],
                                      MODE_RST_VAL[`LVD_MODE_RST_BIT]});
    end else if (wr_en && sel == lvd_pkg::LVD_SEL_MODE && unlock_q && !cfg_locked) begin
      // Once armed, neither bit can be cleared by software
      mode_q.detect_enable     <= apb_req_i.pwdata[`LVD_MODE_EN_BIT] || armed;
      mode_q.reset_mode_select <= apb_req_i.pwdata[`LVD_MODE_RST_BIT] || armed;
    end
  end

  // Level register; only the code field is stored, upper bits read zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      level_q <= LEVEL_RST_VAL[`LVD_LEVEL_MSB:0];
    end else if (wr_en && sel == lvd_pkg::LVD_SEL_LEVEL && !cfg_locked) begin
      level_q <= apb_req_i.pwdata[`LVD_LEVEL_MSB:0];
    end
  end

  // Two stage synchroniser; comparator is asynchronous to the clock
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= cmp_below_i;
      sync2_q <= sync1_q;
    end
  end

  // Status flag: low while disabled, follows the synchronised comparator
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= mode_q.detect_enable && sync2_q;
    end
  end

  // Reset request held for as long as the supply stays low
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= armed && mode_q.detect_enable && sync2_q;
    end
  end

  // Remembers that the detector has requested a reset; frees the lock
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fired_q <= 1'b0;
    end else if (reset_req_q) begin
      fired_q <= 1'b1;
    end
  end

  // Read data registered on the setup cycle, ready for the access cycle
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite) begin
      prdata_q <= 32'h0000_0000;
      unique case (sel)
        lvd_pkg::LVD_SEL_MODE: begin
          prdata_q[`LVD_MODE_EN_BIT]   <= mode_q.detect_enable;
          prdata_q[`LVD_MODE_RST_BIT]  <= mode_q.reset_mode_select;
          prdata_q[`LVD_MODE_FLAG_BIT] <= flag_q;
        end
        lvd_pkg::LVD_SEL_LEVEL: begin
          prdata_q[`LVD_LEVEL_MSB:0] <= level_q;
        end
        lvd_pkg::LVD_SEL_PROTECT,
        lvd_pkg::LVD_SEL_NONE: begin
          prdata_q[0] <= 1'b0;
        end
      endcase
    end
  end

  // APB answer; unmapped addresses give an error and zero data
  always_comb begin
    apb_rsp_o.pready  = 1'b1;
    apb_rsp_o.pslverr = (wr_en || rd_en) && (sel == lvd_pkg::LVD_SEL_NONE);
    apb_rsp_o.prdata  = prdata_q;
  end

  // Outputs; interrupt comes straight from the flag in interrupt mode
  assign supply_drop_irq_o = mode_q.detect_enable && !mode_q.reset_mode_select &&
                             flag_q;
  assign supply_drop_reset_req_o = reset_req_q;
  // One cycle pulse on the first rising edge of the reset request after srst_i
  assign supply_reset_source_flag_set_o = reset_req_q && !fired_q;
  assign cmp_enable_o = mode_q.detect_enable;
  assign level_code_o = level_q;

endmodule

`default_nettype wire

// File: pkg/lvd_map.svh
/*
  Constants of the supply drop detector control block: APB register map,
  field positions, reset values and the protected write key.
  Assumes nothing of its surroundings; holds definitions only.
*/
// Notes on behaviour
// - Enabled detection below level raises interrupt or reset request, per mode.
// - Mode register: enable bit 7, mode bit 1, flag bit 0; rest zero.
// - Writing enable 1 starts comparison; writing 0 stops it in interrupt mode.
// - Mode 0 gives interrupt request, mode 1 gives internal reset request.
// - Flag reads 1 only when enabled and below level; read only.
// - Reset mode asserts reset request whenever enabled comparison finds supply low.
// - Interrupt mode drives interrupt line straight from the flag.
// - With enable and mode both 1, mode writes ignored until reset request.
// - With enable and mode both 1, level writes ignored until reset request.
// - Mode register clears on other resets, keeps value through detector reset.
// - Level register clears on other resets, keeps value through detector reset.
// - Level code 0 to 6 picks 4.3 V down to 3.1 V; 7 prohibited. The code does not reject 7: level_q stores it like any other code.
// - Reset request sets the low-voltage flag of the reset source register; only the first request after srst_i pulses it.
// - Detection and its outputs keep working in STOP mode.
// - Mode register writes only accepted through the protected write sequence.
// - Enabling may raise an interrupt at once if supply already low.
// - Armed reset mode cannot be stopped by software, only by other reset.
`ifndef LVD_MAP_SVH
`define LVD_MAP_SVH

// Register indices; byte address is four times the index
`define LVD_IDX_MODE      12'h090
`define LVD_IDX_LEVEL     12'h091
`define LVD_IDX_PROTECT   12'h092
`define LVD_ADDR_MODE     12'h240
`define LVD_ADDR_LEVEL    12'h244
`define LVD_ADDR_PROTECT  12'h248

// Mode register fields
`define LVD_MODE_EN_BIT   7
`define LVD_MODE_RST_BIT  1
`define LVD_MODE_FLAG_BIT 0

// Level register field
`define LVD_LEVEL_MSB     2
`define LVD_LEVEL_BAD     3'h7

// Reset values
`define LVD_MODE_RST_VAL  8'h00
`define LVD_LEVEL_RST_VAL 8'h00

// Key that opens the protected write window
`define LVD_PROTECT_KEY   8'hA5

// Software settling wait before polling the flag, in ns, and in cycles at 100 ns
`define LVD_SETTLE_NS     200000
`define LVD_CLK_NS        100
`define LVD_SETTLE_CYC    (`LVD_SETTLE_NS / `LVD_CLK_NS)

`endif

// File: pkg/lvd_pkg.sv
/*
  Types of the supply drop detector control block: APB request carrier,
  APB answer carrier and the mode register layout.
  Assumes the constants header lvd_map.svh for field positions.
*/
`default_nettype none
package lvd_pkg;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lvd_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lvd_apb_rsp_s;

  // Stored mode control bits; the flag is live state, not stored here
  typedef struct packed {
    logic detect_enable;
    logic reset_mode_select;
  } lvd_mode_s;

  // Which register an APB address selects
  typedef enum logic [1:0] {
    LVD_SEL_NONE,
    LVD_SEL_MODE,
    LVD_SEL_LEVEL,
    LVD_SEL_PROTECT
  } lvd_sel_e;

endpackage
`default_nettype wire

// File: testbench/lvd_cmp_model.sv
/* Behavioural supply comparator facing lvd_ctrl.
   Assumes supply given in tenths of a volt by the bench. */
`timescale 1ns/1ps
`default_nettype none
module lvd_cmp_model (
  // Control from the detector
  input  wire logic       en_i,
  input  wire logic [2:0] code_i,
  // Supply and result
  input  wire logic [7:0] mv_i,
  output logic            below_o
);
  // Code 0 is 4.3 V, each step 0.2 V lower; an idle comparator reports 0
  assign below_o = en_i && (mv_i < 8'h2B - {4'h0, code_i, 1'b0});
endmodule
`default_nettype wire

// File: testbench/lvd_ctrl_bench.sv
/* Self-checking bench for lvd_ctrl over APB with a comparator model.
   Assumes the map header and package are compiled first. */
`timescale 1ns/1ps
`include "lvd_map.svh"
`default_nettype none
module lvd_ctrl_bench;
  logic                  clk_sys_i = 1'b0;
  logic                  srst_i = 1'b1;
  lvd_pkg::lvd_apb_req_s req = '0;
  lvd_pkg::lvd_apb_rsp_s rsp;
  logic                  below, en, irq, rreq;
  logic [2:0]            code;
  logic [7:0]            mv = 8'h32; // Supply 5.0 V
  int                    n_mismatch = 0;
  int                    checked = 0;
  logic                  src;
  int                    n_src = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  lvd_ctrl dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .cmp_below_i(below), .cmp_enable_o(en), .level_code_o(code), .supply_drop_irq_o(irq),
    .supply_drop_reset_req_o(rreq), .supply_reset_source_flag_set_o(src));
  // Counts cycles in which the reset-source pulse stood at a rising edge
  always @(posedge clk_sys_i) if (src === 1'b1) n_src++;
  lvd_cmp_model cmp_u (.en_i(en), .code_i(code), .mv_i(mv), .below_o(below));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen, a read compares the byte
  task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    logic bad;
    n = 0;
    bad = a != `LVD_ADDR_MODE && a != `LVD_ADDR_LEVEL && a != `LVD_ADDR_PROTECT;
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    chk({31'h0, n < 20}, 32'h1);
    if (n >= 20) begin
      tally_and_finish();
    end else begin
      chk({31'h0, rsp.pslverr}, {31'h0, bad});
      if (!w) chk(rsp.prdata, {24'h0, d});
      req <= '0;
    end
  endtask
  task automatic md(input logic w, input logic [7:0] d);
    xf(w, `LVD_ADDR_MODE, d);
  endtask
  task automatic lv(input logic w, input logic [7:0] d);
    xf(w, `LVD_ADDR_LEVEL, d);
  endtask
  // Key then mode write, back to back as the protected sequence needs
  task automatic pm(input logic [7:0] d);
    xf(1'b1, `LVD_ADDR_PROTECT, `LVD_PROTECT_KEY);
    md(1'b1, d);
  endtask
  // Supply change, then wait out the synchroniser and flag stage
  task automatic sup(input logic [7:0] v);
    mv <= v;
    repeat (4) @(posedge clk_sys_i);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    md(1'b0, 8'h00);
    lv(1'b0, 8'h00);
    xf(1'b0, 12'h2FC, 8'h00);
    md(1'b1, 8'h80);
    md(1'b0, 8'h00);
    for (int i = 0; i < 7; i++) begin
      lv(1'b1, 8'(i));
      lv(1'b0, 8'(i));
    end
    lv(1'b1, 8'h02);
    pm(8'h7D);
    md(1'b0, 8'h00);
    pm(8'h80);
    md(1'b0, 8'h80);
    sup(8'h23);
    md(1'b0, 8'h81);
    chk({31'h0, irq}, 32'h1);
    pm(8'h00);
    md(1'b0, 8'h00);
    chk({31'h0, irq}, 32'h0);
    sup(8'h32);
    pm(8'h80);
    repeat (`LVD_SETTLE_CYC) @(posedge clk_sys_i);
    md(1'b0, 8'h80);
    pm(8'h82);
    md(1'b0, 8'h82);
    lv(1'b1, 8'h05);
    lv(1'b0, 8'h02);
    pm(8'h00);
    md(1'b0, 8'h82);
    sup(8'h23);
    chk({30'h0, rreq, irq}, 32'h2);
    sup(8'h32);
    chk({31'h0, rreq}, 32'h0);
    chk(n_src, 32'h1);
    pm(8'h00);
    md(1'b0, 8'h82);
    chk(n_src, 32'h1);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    md(1'b0, 8'h00);
    lv(1'b0, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: testbench/lvd_ctrl_chk.sv
/* Port checker for lvd_ctrl.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "lvd_map.svh"
`default_nettype none
module lvd_ctrl_chk (
  // Watched ports
  input wire logic                  clk_sys_i,
  input wire logic                  srst_i,
  input wire lvd_pkg::lvd_apb_req_s apb_req_i,
  input wire logic                  cmp_below_i,
  input wire logic                  cmp_enable_o,
  input wire logic [2:0]            level_code_o,
  input wire logic                  supply_drop_irq_o,
  input wire logic                  supply_drop_reset_req_o,
  input wire logic                  supply_reset_source_flag_set_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Requests trail the comparator by the two-flop synchroniser and the flag or request register
  chk_irq_cause: assert property (supply_drop_irq_o |-> $past(cmp_below_i, 3))
    else $error("irq without low supply");
  chk_rst_cause: assert property (supply_drop_reset_req_o |-> $past(cmp_below_i, 3))
    else $error("reset request without low supply");
  chk_detect_resp: assert property (cmp_enable_o && $past(cmp_enable_o)
    && $past(cmp_enable_o, 3) && $past(cmp_below_i, 3)
    |-> supply_drop_irq_o || supply_drop_reset_req_o) else $error("low supply missed");
  chk_off_quiet: assert property (!cmp_enable_o
    |-> !supply_drop_irq_o && !supply_drop_reset_req_o) else $error("output while off");
  chk_one_kind: assert property (!(supply_drop_irq_o && supply_drop_reset_req_o))
    else $error("both requests");
  chk_src_pulse: assert property ($rose(supply_reset_source_flag_set_o)
    |-> supply_drop_reset_req_o ##1 !supply_reset_source_flag_set_o) else $error("bad pulse");
  chk_armed_hold: assert property ($rose(supply_drop_reset_req_o) |-> cmp_enable_o [*8])
    else $error("detection stopped");
  // Level changes only through a completed write to its address
  chk_lvl_write: assert property ($changed(level_code_o) |-> $past(apb_req_i.psel
    && apb_req_i.penable && apb_req_i.pwrite && apb_req_i.paddr == `LVD_ADDR_LEVEL))
    else $error("level changed without write");
endmodule
bind lvd_ctrl lvd_ctrl_chk chk_u (
  .clk_sys_i                      (clk_sys_i),
  .srst_i                         (srst_i),
  .apb_req_i                      (apb_req_i),
  .cmp_below_i                    (cmp_below_i),
  .cmp_enable_o                   (cmp_enable_o),
  .level_code_o                   (level_code_o),
  .supply_drop_irq_o              (supply_drop_irq_o),
  .supply_drop_reset_req_o        (supply_drop_reset_req_o),
  .supply_reset_source_flag_set_o (supply_reset_source_flag_set_o)
);
`default_nettype wire
